//--- design/lbc_config_regs.sv
// Configuration registers of the LED boost driver, reached over the serial pins.
// Assumes scl/sda already synchronous to clk_sys_i and analog compares outside.
// Function
// - Soft-start code picks 1/16/128/512 us steps.
// - Step ramp only at power-on, not later.
// - Lowest code holds each step 1 us.
// - Output divider code divides 26 kHz output.
// - Division only in PWM-pin brightness mode.
// - Light-load bit clear keeps programmed frequency.
// - Light-load bit set lowers frequency on short on-time.
// - Six-bit code sets lowest light-load frequency.
// - Five-bit code maps 10 V to 40 V.
// - Two-bit code selects string headroom limit.
// - Short protection enabled only when bit set.
// - Switch off while output above threshold.
`timescale 1ns/1ps
module lbc_config_regs
   import lbc_pkg::*;
#(
   parameter int SS_CYC_0 = LBC_SS_CYC_0,
   parameter int SS_CYC_1 = LBC_SS_CYC_1,
   parameter int SS_CYC_2 = LBC_SS_CYC_2,
   parameter int SS_CYC_3 = LBC_SS_CYC_3,
   parameter int PWM_OUT_CYC = LBC_PWM_OUT_CYC
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic pwm_input_mode_i,
   input wire logic [11:0] brightness_target_i,
   output logic [11:0] brightness_o,
   output logic soft_start_active_o,
   output logic pwm_output_signal_o,
   input wire logic on_time_short_i,
   input wire logic [15:0] sw_period_ticks_i,
   output logic pfm_enable_o,
   output logic sw_freq_reduce_o,
   output logic [15:0] pfm_max_period_o,
   output logic [5:0] boost_overvoltage_threshold_o,
   output logic [11:0] string_headroom_limit_o,
   output logic short_protect_en_o,
   input wire logic sw_request_i,
   input wire logic vout_over_i,
   output logic boost_switch_gate_o
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic scl_q;
      logic sda_q;
      lbc_bus_st_t bus;
      lbc_phase_t ph;
      logic [3:0] bitc;
      logic [7:0] shf;
      logic [7:0] ptr;
      logic rw;
      logic ackd;
      logic sda_oe;
      logic [1:0] ss_code;
      logic [2:0] div_code;
      logic pfm_en;
      logic [5:0] pfm_code;
      logic [4:0] ovp_code;
      logic [1:0] hr_code;
      logic short_en;
      logic ss_active;
      logic [15:0] ss_cnt;
      logic [11:0] bright;
      logic [3:0] pre_cnt;
      logic [12:0] base_cnt;
      logic pwm_out;
      logic gate;
   } lbc_state_t;

   localparam lbc_state_t RST_STATE = '{
      scl_q: 1'b1, sda_q: 1'b1, bus: LBC_ST_IDLE, ph: LBC_PH_ADDR,
      bitc: 4'h0, shf: 8'h00, ptr: 8'h00, rw: 1'b0, ackd: 1'b0, sda_oe: 1'b0,
      ss_code: LBC_SS_RST, div_code: LBC_DIV_RST, pfm_en: LBC_PFM_EN_RST,
      pfm_code: LBC_PFM_CODE_RST, ovp_code: LBC_OVP_RST, hr_code: LBC_HR_RST,
      short_en: LBC_SHORT_RST, ss_active: 1'b1, ss_cnt: 16'h0000,
      bright: 12'h000, pre_cnt: 4'h0, base_cnt: 13'h0000, pwm_out: 1'b0,
      gate: 1'b0};

   lbc_state_t q_r;
   lbc_state_t q_nxt;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic scl_rise;
      logic scl_fall;
      logic start_c;
      logic stop_c;
      logic [7:0] rdata;
      logic [15:0] step_cyc;
      logic [2:0] div_exp;
      logic [3:0] div_mask;
      logic [24:0] duty_prod;
      scl_rise = 1'b0;
      scl_fall = 1'b0;
      start_c = 1'b0;
      stop_c = 1'b0;
      rdata = 8'h00;
      step_cyc = 16'h0000;
      div_exp = 3'h0;
      div_mask = 4'h0;
      duty_prod = 25'h0000000;
      q_nxt = q_r;
      q_nxt.scl_q = scl_i;
      q_nxt.sda_q = sda_i;
      scl_rise = scl_i & ~q_r.scl_q;
      scl_fall = ~scl_i & q_r.scl_q;
      start_c = scl_i & q_r.scl_q & q_r.sda_q & ~sda_i;
      stop_c = scl_i & q_r.scl_q & ~q_r.sda_q & sda_i;

      // read back mux
      // Unused bits read zero; unmapped pointers read zero
      unique case (q_r.ptr)
         LBC_OFS_SS_DIV: rdata = {q_r.div_code, 3'h0, q_r.ss_code};
         LBC_OFS_LIGHT_LOAD: rdata = {1'b0, q_r.pfm_code, q_r.pfm_en};
         LBC_OFS_PROTECT: rdata = {q_r.short_en, q_r.hr_code, q_r.ovp_code};
         default: rdata = 8'h00;
      endcase

      // Serial slave: sample on rising, drive on falling
      if (start_c) begin
         q_nxt.bus = LBC_ST_RX;
         q_nxt.ph = LBC_PH_ADDR;
         q_nxt.bitc = 4'h0;
         q_nxt.sda_oe = 1'b0;
      end else if (stop_c) begin
         q_nxt.bus = LBC_ST_IDLE;
         q_nxt.sda_oe = 1'b0;
      end else begin
         unique case (q_r.bus)
            LBC_ST_IDLE: begin
               q_nxt.sda_oe = 1'b0;
            end
            LBC_ST_RX: begin
               if (scl_rise) begin
                  q_nxt.shf = {q_r.shf[6:0], sda_i};
                  q_nxt.bitc = q_r.bitc + 4'h1;
               end else if (scl_fall && q_r.bitc == 4'h8) begin
                  q_nxt.bus = LBC_ST_ACK;
                  q_nxt.sda_oe = 1'b1;
                  unique case (q_r.ph)
                     LBC_PH_ADDR: begin
                        q_nxt.rw = q_r.shf[0];
                        if (q_r.shf[7:1] != LBC_DEV_ADDR) begin
                           // Not ours: stay off the line until next start
                           q_nxt.bus = LBC_ST_IDLE;
                           q_nxt.sda_oe = 1'b0;
                        end
                     end
                     LBC_PH_PTR: q_nxt.ptr = q_r.shf;
                     default: begin
                        unique case (q_r.ptr)
                           LBC_OFS_SS_DIV: begin
                              q_nxt.ss_code = q_r.shf[LBC_SS_LSB +: 2];
                              q_nxt.div_code = q_r.shf[LBC_DIV_LSB +: 3];
                           end
                           LBC_OFS_LIGHT_LOAD: begin
                              q_nxt.pfm_en = q_r.shf[LBC_PFM_EN_BIT];
                              q_nxt.pfm_code = q_r.shf[LBC_PFM_CODE_LSB +: 6];
                           end
                           LBC_OFS_PROTECT: begin
                              q_nxt.ovp_code = q_r.shf[LBC_OVP_LSB +: 5];
                              q_nxt.hr_code = q_r.shf[LBC_HR_LSB +: 2];
                              q_nxt.short_en = q_r.shf[LBC_SHORT_BIT];
                           end
                           default: q_nxt.ptr = q_r.ptr;
                        endcase
                        q_nxt.ptr = q_r.ptr + 8'h01;
                     end
                  endcase
               end
            end
            LBC_ST_ACK: begin
               if (scl_fall) begin
                  q_nxt.bitc = 4'h0;
                  if (q_r.rw) begin
                     q_nxt.bus = LBC_ST_TX;
                     q_nxt.shf = rdata;
                     q_nxt.ptr = q_r.ptr + 8'h01;
                     q_nxt.sda_oe = ~rdata[7];
                  end else begin
                     q_nxt.bus = LBC_ST_RX;
                     q_nxt.sda_oe = 1'b0;
                     q_nxt.ph = (q_r.ph == LBC_PH_ADDR) ? LBC_PH_PTR : LBC_PH_DATA;
                  end
               end
            end
            LBC_ST_TX: begin
               if (scl_fall) begin
                  if (q_r.bitc == 4'h7) begin
                     q_nxt.bus = LBC_ST_RACK;
                     q_nxt.sda_oe = 1'b0;
                  end else begin
                     q_nxt.shf = {q_r.shf[6:0], 1'b0};
                     q_nxt.sda_oe = ~q_r.shf[6];
                     q_nxt.bitc = q_r.bitc + 4'h1;
                  end
               end
            end
            LBC_ST_RACK: begin
               if (scl_rise) begin
                  q_nxt.ackd = ~sda_i;
               end else if (scl_fall) begin
                  q_nxt.bitc = 4'h0;
                  if (q_r.ackd) begin
                     q_nxt.bus = LBC_ST_TX;
                     q_nxt.shf = rdata;
                     q_nxt.ptr = q_r.ptr + 8'h01;
                     q_nxt.sda_oe = ~rdata[7];
                  end else begin
                     q_nxt.bus = LBC_ST_IDLE;
                  end
               end
            end
            default: q_nxt.bus = LBC_ST_IDLE;
         endcase
      end

      unique case (q_r.ss_code)
         2'h0: step_cyc = SS_CYC_0[15:0];
         2'h1: step_cyc = SS_CYC_1[15:0];
         2'h2: step_cyc = SS_CYC_2[15:0];
         2'h3: step_cyc = SS_CYC_3[15:0];
      endcase

      // ramp only after power-on
      // Later target changes pass straight through
      if (q_r.ss_active) begin
         if (q_r.bright >= brightness_target_i) begin
            q_nxt.ss_active = 1'b0;
            q_nxt.bright = brightness_target_i;
         end else if (q_r.ss_cnt >= step_cyc - 16'h0001) begin
            q_nxt.ss_cnt = 16'h0000;
            q_nxt.bright = q_r.bright + 12'h001;
         end else begin
            q_nxt.ss_cnt = q_r.ss_cnt + 16'h0001;
         end
      end else begin
         q_nxt.bright = brightness_target_i;
      end

      // divide by 1, 2, 4, 8 or 16
      if (!pwm_input_mode_i) begin
         div_exp = 3'h0;
      end else if (q_r.div_code[2]) begin
         div_exp = 3'h4;
      end else begin
         div_exp = {1'b0, q_r.div_code[1:0]};
      end
      div_mask = 4'((5'h01 << div_exp) - 5'h01);
      q_nxt.pre_cnt = q_r.pre_cnt + 4'h1;
      if ((q_r.pre_cnt & div_mask) == div_mask) begin
         if (q_r.base_cnt >= 13'(PWM_OUT_CYC - 1)) begin
            q_nxt.base_cnt = 13'h0000;
            q_nxt.pre_cnt = 4'h0;
         end else begin
            q_nxt.base_cnt = q_r.base_cnt + 13'h0001;
         end
      end
      // Duty follows the current brightness level
      duty_prod = 25'(q_r.bright) * 25'(PWM_OUT_CYC);
      q_nxt.pwm_out = (q_r.base_cnt < duty_prod[24:12]);

      q_nxt.gate = sw_request_i & ~vout_over_i;
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q_r <= RST_STATE;
      end else begin
         q_r <= q_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Open drain: only ever pull low
   assign sda_o = 1'b0;
   assign sda_oe_o = q_r.sda_oe;
   assign brightness_o = q_r.bright;
   assign soft_start_active_o = q_r.ss_active;
   assign pwm_output_signal_o = q_r.pwm_out;
   assign boost_switch_gate_o = q_r.gate;
   assign short_protect_en_o = q_r.short_en;
   assign pfm_enable_o = q_r.pfm_en;
   // reduce only when on-time too short
   assign sw_freq_reduce_o = q_r.pfm_en & on_time_short_i;
   // period in 16 MHz ticks, inverse of frequency
   assign pfm_max_period_o = sw_period_ticks_i + {7'h00, q_r.pfm_code, 3'h0}
      + {11'h000, LBC_PFM_OFS};
   // 10 V plus code, saturating at 40 V
   assign boost_overvoltage_threshold_o = (q_r.ovp_code >= LBC_OVP_MAX_CODE) ?
      LBC_OVP_MAX_V : LBC_OVP_BASE_V + {1'b0, q_r.ovp_code};

   always_comb begin
      unique case (q_r.hr_code)
         2'h0: string_headroom_limit_o = LBC_HR_MV_0;
         2'h1: string_headroom_limit_o = LBC_HR_MV_1;
         2'h2: string_headroom_limit_o = LBC_HR_MV_2;
         2'h3: string_headroom_limit_o = LBC_HR_MV_3;
      endcase
   end

endmodule

//--- shared/lbc_pkg.sv
// Package for the LED boost configuration register block.
// Assumes a single 125 MHz core clock; analog parts sit outside.
package lbc_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] LBC_OFS_SS_DIV = 8'h08;
   localparam logic [7:0] LBC_OFS_LIGHT_LOAD = 8'h09;
   localparam logic [7:0] LBC_OFS_PROTECT = 8'h0a;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int LBC_SS_LSB = 0;      // Soft-start code [1:0]
   localparam int LBC_DIV_LSB = 5;     // Output divider [7:5]
   localparam int LBC_PFM_EN_BIT = 0;  // Light-load enable [0]
   localparam int LBC_PFM_CODE_LSB = 1; // Lowest frequency code [6:1]
   localparam int LBC_OVP_LSB = 0;     // Boost threshold code [4:0]
   localparam int LBC_HR_LSB = 5;      // Headroom level [6:5]
   localparam int LBC_SHORT_BIT = 7;   // Short protection enable [7]

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [1:0] LBC_SS_RST = 2'h0;
   localparam logic [2:0] LBC_DIV_RST = 3'h0;
   localparam logic LBC_PFM_EN_RST = 1'b0;
   localparam logic [5:0] LBC_PFM_CODE_RST = 6'h3c;
   localparam logic [4:0] LBC_OVP_RST = 5'h1a;
   localparam logic [1:0] LBC_HR_RST = 2'h0;
   localparam logic LBC_SHORT_RST = 1'b0;

   // ****************************************
   // Threshold encodings
   // ****************************************
   localparam logic [4:0] LBC_OVP_MAX_CODE = 5'h1e;
   localparam logic [5:0] LBC_OVP_BASE_V = 6'h0a;
   localparam logic [5:0] LBC_OVP_MAX_V = 6'h28;
   localparam logic [11:0] LBC_HR_MV_0 = 12'h834;  // 2.1 V
   localparam logic [11:0] LBC_HR_MV_1 = 12'h9d8;  // 2.52 V
   localparam logic [11:0] LBC_HR_MV_2 = 12'haf0;  // 2.8 V
   localparam logic [11:0] LBC_HR_MV_3 = 12'hdac;  // 3.5 V
   localparam logic [4:0] LBC_PFM_OFS = 5'h07;     // Constant period term

   // ****************************************
   // Timing
   // ****************************************
   localparam int LBC_CLK_MHZ = 125;
   localparam int LBC_CLK_HZ = 125_000_000;
   localparam int LBC_SS_US_0 = 1;
   localparam int LBC_SS_US_1 = 16;
   localparam int LBC_SS_US_2 = 128;
   localparam int LBC_SS_US_3 = 512;
   localparam int LBC_SS_CYC_0 = LBC_SS_US_0 * LBC_CLK_MHZ;
   localparam int LBC_SS_CYC_1 = LBC_SS_US_1 * LBC_CLK_MHZ;
   localparam int LBC_SS_CYC_2 = LBC_SS_US_2 * LBC_CLK_MHZ;
   localparam int LBC_SS_CYC_3 = LBC_SS_US_3 * LBC_CLK_MHZ;
   localparam int LBC_PWM_OUT_HZ = 26000;
   localparam int LBC_PWM_OUT_CYC = LBC_CLK_HZ / LBC_PWM_OUT_HZ;

   // Serial slave address, arbitrary value
   localparam logic [6:0] LBC_DEV_ADDR = 7'h2a;

   // ****************************************
   // Serial slave states
   // ****************************************
   typedef enum logic [2:0] {
      LBC_ST_IDLE = 3'b000,
      LBC_ST_RX = 3'b001,
      LBC_ST_ACK = 3'b010,
      LBC_ST_TX = 3'b011,
      LBC_ST_RACK = 3'b100
   } lbc_bus_st_t;

   typedef enum logic [1:0] {
      LBC_PH_ADDR = 2'b00,
      LBC_PH_PTR = 2'b01,
      LBC_PH_DATA = 2'b10
   } lbc_phase_t;

endpackage

//--- sim/lbc_host_model.sv
// Serial host model that drives the clock and data lines of the block.
// Assumes open-drain data with a pull-up, one host and no clock stretching.
`timescale 1ns/1ps
module lbc_host_model (
   input wire logic clk_i,
   input wire logic sda_oe_i,
   output logic scl_o,
   output logic sda_o
);
   logic sda_q;

   // Wired-and line: a released line floats high through the pull-up
   assign sda_o = sda_q & !sda_oe_i;

   // Idle bus at time zero
   initial begin
      scl_o = 1'b1;
      sda_q = 1'b1;
   end

   // Third of a bit of four clocks keeps each clock phase above three
   task automatic tick();
      repeat (4) @(posedge clk_i);
   endtask

   // One bit; sampled late in the high phase, where the device holds it
   task automatic bit_x(input logic b, output logic r);
      sda_q <= b;
      tick();
      scl_o <= 1'b1;
      tick();
      r = sda_o;
      scl_o <= 1'b0;
      tick();
   endtask

   // Start and repeated start: data falls while clock is high
   task automatic start();
      sda_q <= 1'b1;
      tick();
      scl_o <= 1'b1;
      tick();
      sda_q <= 1'b0;
      tick();
      scl_o <= 1'b0;
      tick();
   endtask

   task automatic stop();
      sda_q <= 1'b0;
      tick();
      scl_o <= 1'b1;
      tick();
      sda_q <= 1'b1;
      tick();
   endtask

   // Byte out MSB first plus ninth bit; returns the line seen on all nine
   task automatic xfer(input logic [7:0] d, input logic a, output logic [8:0] r);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r[i+1]);
      end
      bit_x(a, r[0]);
   endtask
endmodule

//--- sim/lbc_config_monitor.sv
// Checker of the LED boost configuration block.
// Assumes it is bound onto lbc_config_regs and sees its ports only.
`timescale 1ns/1ps
module lbc_config_monitor (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [11:0] brightness_target_i,
   input wire logic [11:0] brightness_o,
   input wire logic soft_start_active_o,
   input wire logic on_time_short_i,
   input wire logic [15:0] sw_period_ticks_i,
   input wire logic pfm_enable_o,
   input wire logic sw_freq_reduce_o,
   input wire logic [15:0] pfm_max_period_o,
   input wire logic [5:0] boost_overvoltage_threshold_o,
   input wire logic sw_request_i,
   input wire logic vout_over_i,
   input wire logic boost_switch_gate_o
);
   logic [15:0] pfm_gap;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   // Extra period over the base; must be 8*code+7
   assign pfm_gap = pfm_max_period_o - sw_period_ticks_i;

   a_gate_off: assert property (
      vout_over_i |=> !boost_switch_gate_o) else $error("switch on above threshold");
   a_gate_on: assert property (
      sw_request_i && !vout_over_i |=> boost_switch_gate_o) else $error("switch stuck off");
   a_freq_cut: assert property (
      sw_freq_reduce_o == (pfm_enable_o && on_time_short_i)) else $error("frequency cut wrong");
   a_pfm_span: assert property (
      pfm_gap[2:0] == 3'h7 && pfm_gap <= 16'd511) else $error("lowest frequency period off");
   a_ovp_volts: assert property (
      boost_overvoltage_threshold_o inside {[6'h0a:6'h28]}) else $error("threshold out of range");
   a_ramp_step: assert property (
      soft_start_active_o ##1 soft_start_active_o |-> brightness_o == $past(brightness_o)
      || brightness_o == $past(brightness_o) + 12'h001) else $error("ramp jumped");
   a_ramp_once: assert property (
      !soft_start_active_o |=> !soft_start_active_o) else $error("ramp restarted");
   a_ramp_done: assert property (
      !soft_start_active_o ##1 (!soft_start_active_o && $stable(brightness_target_i))
      |-> brightness_o == brightness_target_i) else $error("brightness not direct");
endmodule

bind lbc_config_regs lbc_config_monitor mon_u (
   .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .brightness_target_i(brightness_target_i),
   .brightness_o(brightness_o), .soft_start_active_o(soft_start_active_o),
   .on_time_short_i(on_time_short_i), .sw_period_ticks_i(sw_period_ticks_i),
   .pfm_enable_o(pfm_enable_o), .sw_freq_reduce_o(sw_freq_reduce_o),
   .pfm_max_period_o(pfm_max_period_o),
   .boost_overvoltage_threshold_o(boost_overvoltage_threshold_o),
   .sw_request_i(sw_request_i), .vout_over_i(vout_over_i),
   .boost_switch_gate_o(boost_switch_gate_o));

//--- sim/lbc_config_regs_tb.sv
// Testbench of the LED boost configuration block.
// Assumes the host model in lbc_host_model and short step counts.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("unexpected at %0t: got %0h want %0h", $time, (a), (b)); end end
module lbc_config_regs_tb import lbc_pkg::*;;
   localparam int PWC = 20;
   int fail_count = 0;
   int total_checks = 0;
   int n;
   int p;
   logic clk, nrst, scl, sda, oe, mode, shrt, req, over, ss, pw, pen, red, shp, gate, sdo;
   logic [11:0] tgt, bri, hr, b0;
   logic [15:0] ticks, pmax;
   logic [5:0] ovp;
   logic [8:0] r;
   logic [7:0] pd [4] = '{8'h00, 8'h3e, 8'hdf, 8'he5};
   logic [5:0] pv [4] = '{6'h0a, 6'h28, 6'h28, 6'h0f};
   logic [11:0] pm [4] = '{12'h834, 12'h9d8, 12'haf0, 12'hdac};
   logic [2:0] dv [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
   int sh [6] = '{0, 1, 2, 3, 4, 4};

   lbc_host_model host_u (.clk_i(clk), .sda_oe_i(oe), .scl_o(scl), .sda_o(sda));

   lbc_config_regs #(.SS_CYC_0(2), .SS_CYC_1(4), .SS_CYC_2(8), .SS_CYC_3(16),
      .PWM_OUT_CYC(PWC)) dut_u (
      .clk_sys_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe),
      .pwm_input_mode_i(mode), .brightness_target_i(tgt), .brightness_o(bri),
      .soft_start_active_o(ss), .pwm_output_signal_o(pw), .on_time_short_i(shrt),
      .sw_period_ticks_i(ticks), .pfm_enable_o(pen), .sw_freq_reduce_o(red),
      .pfm_max_period_o(pmax), .boost_overvoltage_threshold_o(ovp),
      .string_headroom_limit_o(hr), .short_protect_en_o(shp), .sw_request_i(req),
      .vout_over_i(over), .boost_switch_gate_o(gate));

   always #4 clk = ~clk;

   // ****************************************
   // Bus and measuring tasks
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_u.start();
      host_u.xfer({LBC_DEV_ADDR, 1'b0}, 1'b1, r);
      `CHK(r[0], 1'b0)
      host_u.xfer(a, 1'b1, r);
      host_u.xfer(d, 1'b1, r);
      `CHK(r[0], 1'b0)
      host_u.stop();
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      host_u.start();
      host_u.xfer({LBC_DEV_ADDR, 1'b0}, 1'b1, r);
      host_u.xfer(a, 1'b1, r);
      host_u.start();
      host_u.xfer({LBC_DEV_ADDR, 1'b1}, 1'b1, r);
      host_u.xfer(8'hff, 1'b1, r);
      host_u.stop();
      `CHK(r[8:1], e)
   endtask

   // Bounded wait for a level on the output wave
   task automatic wt(input logic v, inout int c);
      while (pw !== v && c < 2000) begin
         @(posedge clk);
         c++;
      end
   endtask

   // Rise to rise; a second pass skips the period cut by a write
   task automatic per(output int q);
      for (int k = 0; k < 2; k++) begin
         q = 0;
         wt(1'b0, q);
         wt(1'b1, q);
         q = 0;
         wt(1'b0, q);
         wt(1'b1, q);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      {mode, shrt, req, over} = 4'h0;
      tgt = 12'h008;
      ticks = 16'h0064;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      n = 0;
      @(posedge clk);
      while (ss === 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      `CHK(n inside {[15:18]}, 1'b1)
      `CHK(bri, 12'h008)
      tgt <= 12'h800;
      repeat (2) @(posedge clk);
      `CHK(bri, 12'h800)
      rd(LBC_OFS_SS_DIV, 8'h00);
      rd(LBC_OFS_LIGHT_LOAD, 8'h78);
      rd(LBC_OFS_PROTECT, 8'h1a);
      `CHK({ovp, hr, shp, pen}, {6'h24, 12'h834, 2'b00})
      // Foreign address must stay unanswered
      host_u.start();
      host_u.xfer(8'h20, 1'b1, r);
      host_u.stop();
      `CHK(r[0], 1'b1)
      // Open drain: the data pin itself may only ever pull low
      `CHK(sdo, 1'b0)
      wr(LBC_OFS_SS_DIV, 8'hff);
      rd(LBC_OFS_SS_DIV, 8'he3);
      wr(LBC_OFS_LIGHT_LOAD, 8'hff);
      rd(LBC_OFS_LIGHT_LOAD, 8'h7f);
      shrt <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      `CHK({pen, red, pmax}, {2'b11, 16'h0064 + 16'd511})
      wr(LBC_OFS_LIGHT_LOAD, 8'h00);
      @(negedge clk);
      `CHK({pen, red, pmax}, {2'b00, 16'h006b})
      for (int i = 0; i < 4; i++) begin
         wr(LBC_OFS_PROTECT, pd[i]);
         rd(LBC_OFS_PROTECT, pd[i]);
         `CHK({ovp, hr, shp}, {pv[i], pm[i], pd[i][7]})
      end
      wr(8'h0b, 8'h5a);
      rd(8'h0b, 8'h00);
      mode <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         wr(LBC_OFS_SS_DIV, {dv[i], 5'h00});
         per(p);
         `CHK(p, PWC << sh[i])
      end
      mode <= 1'b0;
      per(p);
      `CHK(p, PWC)
      wr(LBC_OFS_SS_DIV, 8'h00);
      req <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(gate, 1'b1)
      over <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(gate, 1'b0)
      // Second power-on: registers back to defaults, ramp restarts
      nrst <= 1'b0;
      tgt <= 12'h100;
      repeat (10) @(posedge clk);
      `CHK({ss, bri, ovp}, {1'b1, 12'h000, 6'h24})
      nrst <= 1'b1;
      // Slowest code written mid-ramp must stretch the next full step to 16 clocks
      wr(LBC_OFS_SS_DIV, 8'h03);
      for (int k = 0; k < 2; k++) begin
         b0 = bri;
         n = 0;
         while (bri === b0 && n < 100) begin
            @(posedge clk);
            n++;
         end
      end
      `CHK(n, 16)
      wrap_up();
   end

   // Run needs about 15000 clocks; cut off well beyond that
   initial begin
      #600000;
      fail_count++;
      wrap_up();
   end
endmodule
